// ===== hw/call_timing.sv
/*
  Timing model for call, return, trap and displacement-addressed moves.
  Assumes the request is synchronous to clk and the configuration bits are
  static straps that may come from another domain, so they are synchronised.
*/
`timescale 1ns/100ps
module call_timing
  import call_timing_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  // Configuration straps
  input wire logic sourceMode,
  input wire logic interrupt_frame_extend,
  input wire logic wait_count_select_hi,
  input wire logic wait_count_select_lo,
  // Request
  input wire logic reqValid,
  input wire request_s req,
  // Result
  output logic resValid,
  output result_s res
);

  typedef struct packed {
    logic [3:0] cfgMeta;
    logic [3:0] cfgSync;
    logic resValid;
    result_s res;
  } state_s;

  state_s state_reg;
  state_s state_next;

  function automatic logic [5:0] waitCount(input logic hi, input logic lo);
    if (!hi && !lo) begin
      return WAIT_00;
    end else if (!hi && lo) begin
      return WAIT_01;
    end else begin
      return WAIT_1X;
    end
  endfunction : waitCount

  function automatic logic [5:0] pick(input logic src, input logic [5:0] b,
                                      input logic [5:0] s);
    return src ? s : b;
  endfunction : pick

  logic src;
  logic frameWide;
  logic [5:0] waitN;
  logic isCall;
  logic isReturn;
  logic isMove;
  logic [2:0] bytesC;
  logic [5:0] baseC;
  logic [5:0] addC;
  logic [5:0] extAddC;

  always_comb begin
    state_next = state_reg;
    src = state_reg.cfgSync[3];
    frameWide = state_reg.cfgSync[2];
    waitN = waitCount(state_reg.cfgSync[1], state_reg.cfgSync[0]);
    isCall = 1'b0;
    isReturn = 1'b0;
    isMove = 1'b0;
    bytesC = B_ONE;
    baseC = S_RETURN;
    extAddC = 6'h00;
    case (req.op)
      OP_ABSOLUTE_CALL: begin
        isCall = 1'b1;
        bytesC = B_ABS_CALL;
        baseC = S_ABS_CALL;
      end
      OP_EXT_CALL_DIRECT: begin
        isCall = 1'b1;
        bytesC = src ? B_EXT_CALL_SRC : B_EXT_CALL_BIN;
        baseC = pick(src, S_EXT_CALL_BIN, S_EXT_CALL_SRC);
      end
      OP_EXT_CALL_DWORD: begin
        isCall = 1'b1;
        bytesC = src ? B_IND_SRC : B_IND_BIN;
        baseC = pick(src, S_EXT_CALL_BIN, S_EXT_CALL_SRC);
      end
      OP_LONG_CALL_WORD: begin
        isCall = 1'b1;
        bytesC = src ? B_IND_SRC : B_IND_BIN;
        baseC = pick(src, S_LONG_W_BIN, S_LONG_W_SRC);
      end
      OP_LONG_CALL_DIRECT: begin
        isCall = 1'b1;
        bytesC = B_LONG_D;
        baseC = S_LONG_D;
      end
      OP_SUB_RETURN: begin
        isReturn = 1'b1;
        bytesC = B_ONE;
        baseC = S_RETURN;
      end
      OP_EXT_RETURN: begin
        isReturn = 1'b1;
        bytesC = src ? B_IND_SRC : B_IND_BIN;
        baseC = pick(src, S_EXT_RETURN_BIN, S_EXT_RETURN_SRC);
      end
      OP_INT_RETURN: begin
        isReturn = 1'b1;
        bytesC = B_ONE;
        baseC = S_RETURN;
      end
      OP_TRAP: begin
        bytesC = src ? B_ONE : B_TRAP_BIN;
        baseC = pick(src, S_TRAP_BIN, S_TRAP_SRC);
      end
      OP_STORE_BYTE_64K: begin
        isMove = 1'b1;
        bytesC = src ? B_MOVE_SRC : B_MOVE_BIN;
        baseC = pick(src, S_ST_B64_BIN, S_ST_B64_SRC);
        extAddC = waitN + ADD_BYTE_K;
      end
      OP_STORE_WORD_64K: begin
        isMove = 1'b1;
        bytesC = src ? B_MOVE_SRC : B_MOVE_BIN;
        baseC = pick(src, S_ST_W64_BIN, S_ST_W64_SRC);
        extAddC = 6'((waitN + ADD_WORD_K) << 1);
      end
      OP_MOVE_BYTE_16M: begin
        isMove = 1'b1;
        bytesC = src ? B_MOVE_SRC : B_MOVE_BIN;
        baseC = pick(src, S_MV_B16_BIN, S_MV_B16_SRC);
        extAddC = waitN + ADD_BYTE_K;
      end
      OP_MOVE_WORD_16M: begin
        isMove = 1'b1;
        bytesC = src ? B_MOVE_SRC : B_MOVE_BIN;
        baseC = pick(src, S_MV_W16_BIN, S_MV_W16_SRC);
        extAddC = 6'((waitN + ADD_WORD_K) << 1);
      end
      OP_MOVE_DWORD_16M: begin
        // The dword form shares the word base; only its external adder differs.
        isMove = 1'b1;
        bytesC = src ? B_MOVE_SRC : B_MOVE_BIN;
        baseC = pick(src, S_MV_W16_BIN, S_MV_W16_SRC);
        extAddC = 6'((waitN + ADD_DWORD_K) << 2);
      end
      default: begin
        bytesC = B_ONE;
        baseC = S_RETURN;
      end
    endcase
    addC = 6'h00;
    if ((isCall || isReturn) && req.execInternal && !req.destExternal && req.destOdd) begin
      addC = addC + ADD_ODD;
    end
    if (isCall && req.destExternal) begin
      addC = addC + ADD_EXT_CALL;
    end
    if ((req.op == OP_INT_RETURN || req.op == OP_TRAP) && frameWide) begin
      addC = addC + ADD_FRAME;
    end
    if (isMove && req.moveTarget == TGT_IO_PORT) begin
      addC = addC + ADD_IO_PORT;
    end else if (isMove && req.moveTarget == TGT_PERIPHERAL) begin
      addC = addC + ADD_PERIPH;
    end else if (isMove && req.moveTarget == TGT_EXTERNAL) begin
      addC = addC + extAddC;
    end
    if (clkEn) begin
      // Straps pass two flops before the timing logic reads them.
      state_next.cfgMeta = {sourceMode, interrupt_frame_extend,
                            wait_count_select_hi, wait_count_select_lo};
      state_next.cfgSync = state_reg.cfgMeta;
      state_next.resValid = reqValid;
      if (reqValid) begin
        state_next.res.bytes = bytesC;
        state_next.res.states = baseC + addC;
        state_next.res.stackFrameWide = frameWide &&
          (req.op == OP_INT_RETURN || req.op == OP_TRAP);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign resValid = state_reg.resValid;
  assign res = state_reg.res;

  absolute_call_a: assert property (@(posedge clk) disable iff (rst)
    clkEn && reqValid && req.op == OP_ABSOLUTE_CALL && !req.destExternal && !req.destOdd
    |=> res.states == S_ABS_CALL && res.bytes == B_ABS_CALL)
    else $error("absolute call timing wrong");

  ext_call_mode_a: assert property (@(posedge clk) disable iff (rst)
    clkEn && reqValid && req.op == OP_EXT_CALL_DIRECT && !req.destExternal && !req.destOdd
    |=> res.states == ($past(state_reg.cfgSync[3]) ? S_EXT_CALL_SRC : S_EXT_CALL_BIN))
    else $error("extended call states wrong");

  long_word_call_a: assert property (@(posedge clk) disable iff (rst)
    clkEn && reqValid && req.op == OP_LONG_CALL_WORD && !req.destOdd && !req.destExternal
    && !state_reg.cfgSync[3] |=> res.states == S_LONG_W_BIN && res.bytes == B_IND_BIN)
    else $error("long indirect call timing wrong");

  sub_return_a: assert property (@(posedge clk) disable iff (rst)
    clkEn && reqValid && req.op == OP_SUB_RETURN && !req.destOdd
    |=> res.states == S_RETURN && res.bytes == B_ONE)
    else $error("return timing wrong");

  odd_target_a: assert property (@(posedge clk) disable iff (rst)
    clkEn && reqValid && req.op == OP_SUB_RETURN && req.destOdd && req.execInternal
    && !req.destExternal |=> res.states == S_RETURN + ADD_ODD)
    else $error("odd target adder missing");

  ext_call_adder_a: assert property (@(posedge clk) disable iff (rst)
    clkEn && reqValid && req.op == OP_LONG_CALL_DIRECT && req.destExternal
    |=> res.states == S_LONG_D + ADD_EXT_CALL)
    else $error("external call adder wrong");

  frame_adder_a: assert property (@(posedge clk) disable iff (rst)
    clkEn && reqValid && req.op == OP_INT_RETURN && state_reg.cfgSync[2] && !req.destOdd
    |=> res.states == S_RETURN + ADD_FRAME && res.stackFrameWide)
    else $error("frame adder wrong");

  io_port_a: assert property (@(posedge clk) disable iff (rst)
    clkEn && reqValid && req.op == OP_MOVE_BYTE_16M && req.moveTarget == TGT_IO_PORT
    && !state_reg.cfgSync[3] |=> res.states == S_MV_B16_BIN + ADD_IO_PORT)
    else $error("port adder wrong");

  dword_ext_a: assert property (@(posedge clk) disable iff (rst)
    clkEn && reqValid && req.op == OP_MOVE_DWORD_16M && req.moveTarget == TGT_EXTERNAL
    && !state_reg.cfgSync[3] && state_reg.cfgSync[1:0] == 2'h0
    |=> res.states == S_MV_W16_BIN + 6'((WAIT_00 + ADD_DWORD_K) << 2))
    else $error("dword external adder wrong");

  hold_idle_a: assert property (@(posedge clk) disable iff (rst)
    !clkEn |=> $stable(res) && $stable(resValid))
    else $error("state moved with clock enable low");

  reset_clear_a: assert property (@(posedge clk)
    rst |=> !resValid && res == '0)
    else $error("outputs not cleared by reset");

  ext_call_dword_a: assert property (@(posedge clk) disable iff (rst)
    clkEn && reqValid && req.op == OP_EXT_CALL_DWORD && !req.destExternal && !req.destOdd
    && !state_reg.cfgSync[3] |=> res.states == S_EXT_CALL_BIN && res.bytes == B_IND_BIN)
    else $error("extended register call timing wrong");

  long_direct_a: assert property (@(posedge clk) disable iff (rst)
    clkEn && reqValid && req.op == OP_LONG_CALL_DIRECT && !req.destExternal && !req.destOdd
    |=> res.states == S_LONG_D && res.bytes == B_LONG_D)
    else $error("long direct call timing wrong");

  ext_return_a: assert property (@(posedge clk) disable iff (rst)
    clkEn && reqValid && req.op == OP_EXT_RETURN && !req.destOdd && state_reg.cfgSync[3]
    |=> res.states == S_EXT_RETURN_SRC && res.bytes == B_IND_SRC)
    else $error("extended return timing wrong");

  int_return_a: assert property (@(posedge clk) disable iff (rst)
    clkEn && reqValid && req.op == OP_INT_RETURN && !req.destOdd && !state_reg.cfgSync[2]
    |=> res.states == S_RETURN && res.bytes == B_ONE && !res.stackFrameWide)
    else $error("interrupt return timing wrong");

  trap_base_a: assert property (@(posedge clk) disable iff (rst)
    clkEn && reqValid && req.op == OP_TRAP && !state_reg.cfgSync[2] && !state_reg.cfgSync[3]
    |=> res.states == S_TRAP_BIN && res.bytes == B_TRAP_BIN)
    else $error("trap timing wrong");

  trap_source_a: assert property (@(posedge clk) disable iff (rst)
    clkEn && reqValid && req.op == OP_TRAP && !state_reg.cfgSync[2] && state_reg.cfgSync[3]
    |=> res.states == S_TRAP_SRC && res.bytes == B_ONE)
    else $error("source mode trap timing wrong");

  store_byte_a: assert property (@(posedge clk) disable iff (rst)
    clkEn && reqValid && req.op == OP_STORE_BYTE_64K && req.moveTarget == TGT_INTERNAL
    && !state_reg.cfgSync[3] |=> res.states == S_ST_B64_BIN && res.bytes == B_MOVE_BIN)
    else $error("byte store timing wrong");

  store_word_a: assert property (@(posedge clk) disable iff (rst)
    clkEn && reqValid && req.op == OP_STORE_WORD_64K && req.moveTarget == TGT_INTERNAL
    && state_reg.cfgSync[3] |=> res.states == S_ST_W64_SRC && res.bytes == B_MOVE_SRC)
    else $error("word store timing wrong");

  move_byte_a: assert property (@(posedge clk) disable iff (rst)
    clkEn && reqValid && req.op == OP_MOVE_BYTE_16M && req.moveTarget == TGT_INTERNAL
    && state_reg.cfgSync[3] |=> res.states == S_MV_B16_SRC)
    else $error("wide byte move timing wrong");

  move_word_a: assert property (@(posedge clk) disable iff (rst)
    clkEn && reqValid && req.op == OP_MOVE_WORD_16M && req.moveTarget == TGT_INTERNAL
    && !state_reg.cfgSync[3] |=> res.states == S_MV_W16_BIN)
    else $error("wide word move timing wrong");

  byte_ext_a: assert property (@(posedge clk) disable iff (rst)
    clkEn && reqValid && req.op == OP_STORE_BYTE_64K && req.moveTarget == TGT_EXTERNAL
    && !state_reg.cfgSync[3] && state_reg.cfgSync[1:0] == 2'h1
    |=> res.states == S_ST_B64_BIN + WAIT_01 + ADD_BYTE_K)
    else $error("byte external adder wrong");

  word_ext_a: assert property (@(posedge clk) disable iff (rst)
    clkEn && reqValid && req.op == OP_MOVE_WORD_16M && req.moveTarget == TGT_EXTERNAL
    && state_reg.cfgSync[3] && state_reg.cfgSync[1]
    |=> res.states == S_MV_W16_SRC + 6'((WAIT_1X + ADD_WORD_K) << 1))
    else $error("word external adder wrong");

  wide_frame_a: assert property (@(posedge clk) disable iff (rst)
    clkEn && reqValid && req.op == OP_TRAP && state_reg.cfgSync[2]
    |=> res.stackFrameWide)
    else $error("wide frame flag missing");

  total_sum_a: assert property (@(posedge clk) disable iff (rst)
    clkEn && reqValid && req.op == OP_INT_RETURN && req.destOdd && req.execInternal
    && !req.destExternal && state_reg.cfgSync[2]
    |=> res.states == S_RETURN + ADD_ODD + ADD_FRAME)
    else $error("adders not summed");

endmodule : call_timing

// ===== hw/call_timing_pkg.sv
/*
  Package for the call, return, trap and displacement-move timing model.
  Assumes a single core clock and synchronous active-high reset.
*/
package call_timing_pkg;

  // Instruction classes presented to the timing model.
  typedef enum logic [3:0] {
    OP_ABSOLUTE_CALL,
    OP_EXT_CALL_DIRECT,
    OP_EXT_CALL_DWORD,
    OP_LONG_CALL_WORD,
    OP_LONG_CALL_DIRECT,
    OP_SUB_RETURN,
    OP_EXT_RETURN,
    OP_INT_RETURN,
    OP_TRAP,
    OP_STORE_BYTE_64K,
    OP_STORE_WORD_64K,
    OP_MOVE_BYTE_16M,
    OP_MOVE_WORD_16M,
    OP_MOVE_DWORD_16M
  } op_e;

  // Target kind of a move.
  typedef enum logic [1:0] {
    TGT_INTERNAL,
    TGT_IO_PORT,
    TGT_PERIPHERAL,
    TGT_EXTERNAL
  } target_e;

  typedef struct packed {
    op_e op;
    target_e moveTarget;
    logic destExternal;
    logic destOdd;
    logic execInternal;
  } request_s;

  typedef struct packed {
    logic [2:0] bytes;
    logic [5:0] states;
    logic stackFrameWide;
  } result_s;

  localparam int STATE_W = 6;

  // Base bytes and states: binary mode, then source mode.
  localparam logic [2:0] B_ABS_CALL = 3'h2;
  localparam logic [5:0] S_ABS_CALL = 6'h09;
  localparam logic [2:0] B_EXT_CALL_BIN = 3'h5;
  localparam logic [2:0] B_EXT_CALL_SRC = 3'h4;
  localparam logic [5:0] S_EXT_CALL_BIN = 6'h0E;
  localparam logic [5:0] S_EXT_CALL_SRC = 6'h0D;
  localparam logic [2:0] B_IND_BIN = 3'h3;
  localparam logic [2:0] B_IND_SRC = 3'h2;
  localparam logic [5:0] S_LONG_W_BIN = 6'h0A;
  localparam logic [5:0] S_LONG_W_SRC = 6'h09;
  localparam logic [2:0] B_LONG_D = 3'h3;
  localparam logic [5:0] S_LONG_D = 6'h09;
  localparam logic [2:0] B_ONE = 3'h1;
  localparam logic [5:0] S_RETURN = 6'h07;
  localparam logic [5:0] S_EXT_RETURN_BIN = 6'h09;
  localparam logic [5:0] S_EXT_RETURN_SRC = 6'h08;
  localparam logic [2:0] B_TRAP_BIN = 3'h2;
  localparam logic [5:0] S_TRAP_BIN = 6'h0C;
  localparam logic [5:0] S_TRAP_SRC = 6'h0B;
  localparam logic [2:0] B_MOVE_BIN = 3'h5;
  localparam logic [2:0] B_MOVE_SRC = 3'h4;
  localparam logic [5:0] S_ST_B64_BIN = 6'h06;
  localparam logic [5:0] S_ST_B64_SRC = 6'h05;
  localparam logic [5:0] S_ST_W64_BIN = 6'h07;
  localparam logic [5:0] S_ST_W64_SRC = 6'h06;
  localparam logic [5:0] S_MV_B16_BIN = 6'h07;
  localparam logic [5:0] S_MV_B16_SRC = 6'h06;
  localparam logic [5:0] S_MV_W16_BIN = 6'h08;
  localparam logic [5:0] S_MV_W16_SRC = 6'h07;

  // Adders.
  localparam logic [5:0] ADD_ODD = 6'h01;
  localparam logic [5:0] ADD_EXT_CALL = 6'h02;
  localparam logic [5:0] ADD_FRAME = 6'h05;
  localparam logic [5:0] ADD_IO_PORT = 6'h01;
  localparam logic [5:0] ADD_PERIPH = 6'h02;
  localparam logic [5:0] ADD_BYTE_K = 6'h02;
  localparam logic [5:0] ADD_WORD_K = 6'h01;
  localparam logic [5:0] ADD_DWORD_K = 6'h02;

  // Wait states for select pins {hi,lo}: 00->3, 01->2, others->1.
  localparam logic [5:0] WAIT_00 = 6'h03;
  localparam logic [5:0] WAIT_01 = 6'h02;
  localparam logic [5:0] WAIT_1X = 6'h01;

endpackage : call_timing_pkg

// ===== bench/ext_mem_waits.sv
/*
  Far-side model: the external memory's wait configuration, set as straps.
  Assumes the bench asks for a wait count of 1, 2 or 3.
*/
`timescale 1ns/100ps
module ext_mem_waits (
  // Wanted wait count
  input wire logic [1:0] waitCount,
  // Select straps
  output logic selHi,
  output logic selLo
);
  // The 11 code also gives one wait; it is left unused, so 10 alone covers it.
  assign selHi = (waitCount == 2'h1);
  assign selLo = (waitCount == 2'h2);
endmodule : ext_mem_waits

// ===== bench/call_return_move_state_timing_test.sv
/*
  Bench for the call, return, trap and move timing model.
  Assumes the design package and the wait-strap model are compiled first.
*/
`timescale 1ns/100ps
module call_return_move_state_timing_test import call_timing_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic sourceMode = 1'b0;
  logic frameExt = 1'b0;
  logic [1:0] waitSet = 2'h3;
  logic selHi;
  logic selLo;
  logic reqValid = 1'b0;
  request_s req = '0;
  logic resValid;
  result_s res;
  int badCount = 0;
  int checksDone = 0;
  int cycleCount = 0;
  int nW = 3;
  int stB[14] = '{9, 14, 14, 10, 9, 7, 9, 7, 12, 6, 7, 7, 8, 8};
  int stS[14] = '{9, 13, 13, 9, 9, 7, 8, 7, 11, 5, 6, 6, 7, 7};
  int byB[14] = '{2, 5, 3, 3, 3, 1, 3, 1, 2, 5, 5, 5, 5, 5};
  int byS[14] = '{2, 4, 2, 2, 3, 1, 2, 1, 1, 4, 4, 4, 4, 4};

  always #5 clk = ~clk;

  ext_mem_waits u_waits (.waitCount(waitSet), .selHi(selHi), .selLo(selLo));

  call_timing u_dut (
    .clk(clk), .rst(rst), .clkEn(clkEn), .sourceMode(sourceMode),
    .interrupt_frame_extend(frameExt), .wait_count_select_hi(selHi),
    .wait_count_select_lo(selLo), .reqValid(reqValid), .req(req),
    .resValid(resValid), .res(res)
  );

  task automatic printVerdict;
    if (badCount == 0 && checksDone > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : printVerdict

  // A hang would leave the run open forever, so a cycle ceiling closes it.
  always @(posedge clk) begin
    cycleCount++;
    if (cycleCount == 2000) begin
      badCount++;
      printVerdict();
    end
  end

  task automatic chk(string name, int expv, logic [5:0] got);
    checksDone++;
    if (got !== expv[5:0]) begin
      badCount++;
      $display("BAD %s expected %0d seen %0d", name, expv, got);
    end
  endtask : chk

  function automatic int expS(int o, target_e t, logic ext, logic odd, logic intl);
    int s;
    s = sourceMode ? stS[o] : stB[o];
    if (o <= 7 && intl && !ext && odd) s += 1;
    if (o <= 4 && ext) s += 2;
    if ((o == 7 || o == 8) && frameExt) s += 5;
    if (o >= 9) begin
      if (t == TGT_IO_PORT) s += 1;
      if (t == TGT_PERIPHERAL) s += 2;
      if (t == TGT_EXTERNAL) s += (o == 13) ? 4 * (nW + 2) : (o % 2) ? nW + 2 : 2 * (nW + 1);
    end
    return s;
  endfunction : expS

  task automatic look(int o, target_e t, logic ext, logic odd, logic intl);
    chk("resValid", 1, {5'h0, resValid});
    chk("states", expS(o, t, ext, odd, intl), res.states);
    chk("bytes", sourceMode ? byS[o] : byB[o], {3'h0, res.bytes});
    chk("wide", (o == 7 || o == 8) && frameExt, {5'h0, res.stackFrameWide});
  endtask : look

  task automatic run(int o, target_e t, logic ext, logic odd, logic intl);
    @(posedge clk);
    #1;
    reqValid = 1'b1;
    req = '{op_e'(o), t, ext, odd, intl};
    @(posedge clk);
    #1;
    reqValid = 1'b0;
    look(o, t, ext, odd, intl);
  endtask : run

  // Straps pass two sync flops, so three edges go by before they count.
  task automatic setCfg(logic m, logic fr, int n);
    @(posedge clk);
    #1;
    sourceMode = m;
    frameExt = fr;
    nW = n;
    waitSet = n[1:0];
    repeat (3) @(posedge clk);
  endtask : setCfg

  task automatic tBase;
    for (int m = 0; m < 2; m++) begin
      setCfg(m[0], 1'b0, 3);
      for (int o = 0; o < 9; o++) run(o, TGT_INTERNAL, 0, 0, 1);
    end
  endtask : tBase

  task automatic tAdders;
    setCfg(1'b0, 1'b0, 3);
    run(0, TGT_INTERNAL, 0, 1, 1);
    run(0, TGT_INTERNAL, 0, 1, 0);
    run(5, TGT_INTERNAL, 0, 1, 1);
    run(1, TGT_INTERNAL, 1, 0, 1);
    run(3, TGT_INTERNAL, 1, 1, 1);
    run(5, TGT_INTERNAL, 1, 0, 1);
    run(4, TGT_INTERNAL, 1, 0, 1);
  endtask : tAdders

  task automatic tFrame;
    setCfg(1'b1, 1'b1, 3);
    run(7, TGT_INTERNAL, 0, 1, 1);
    run(8, TGT_INTERNAL, 0, 0, 1);
    run(7, TGT_INTERNAL, 0, 0, 1);
    run(5, TGT_INTERNAL, 0, 0, 1);
  endtask : tFrame

  task automatic tMoves;
    for (int m = 0; m < 2; m++) begin
      for (int n = 1; n < 4; n++) begin
        setCfg(m[0], 1'b0, n);
        for (int o = 9; o < 14; o++) begin
          for (int t = 0; t < 4; t++) run(o, target_e'(t), 0, 0, 1);
        end
      end
    end
  endtask : tMoves

  task automatic tFreezeAndBurst;
    logic [5:0] held;
    held = res.states;
    @(posedge clk);
    #1;
    clkEn = 1'b0;
    reqValid = 1'b1;
    req = '{OP_ABSOLUTE_CALL, TGT_INTERNAL, 1'b0, 1'b0, 1'b1};
    repeat (2) @(posedge clk);
    #1;
    chk("frozenValid", 0, {5'h0, resValid});
    chk("frozenStates", held, res.states);
    clkEn = 1'b1;
    req = '{OP_SUB_RETURN, TGT_INTERNAL, 1'b0, 1'b0, 1'b1};
    @(posedge clk);
    #1;
    req = '{OP_TRAP, TGT_INTERNAL, 1'b0, 1'b0, 1'b1};
    look(5, TGT_INTERNAL, 0, 0, 1);
    @(posedge clk);
    #1;
    reqValid = 1'b0;
    look(8, TGT_INTERNAL, 0, 0, 1);
  endtask : tFreezeAndBurst

  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("rstValid", 0, {5'h0, resValid});
    chk("rstStates", 0, res.states);
    tBase();
    tAdders();
    tFrame();
    tMoves();
    tFreezeAndBurst();
    printVerdict();
  end
endmodule : call_return_move_state_timing_test
